// file: design/watchdog_timer_24bit.sv
// 24-bit watchdog timer with register port, interrupt and reset request
//
// How it works
// - retriggerable one-shot, resets or interrupts at end
// - counts on dedicated 10 kHz RC oscillator
// - once enabled never stops; software must refresh
// - enabled by refresh instruction or always-on option
// - 24-bit downcounter; reload is upper,high,low bytes
// - time-out ms equals reload divided by ten
// - refresh ignored once count reaches two
// - first enable loads reload then counts down
// - each refresh reloads counter, counting resumes
// - debug mode refreshes counter continuously
// - time-out at zero; option picks reset or interrupt
// - interrupt mode raises request and status bit
// - interrupt time-out wraps to maximum, no reload
// - stop mode time-out starts recovery plus interrupt
// - stop time-out sets status and stop bits
// - interrupt uses vector 0004H, highest peripheral priority
`default_nettype none
module watchdog_timer_24bit
  import wdt_pkg::*;
(
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watchdog rc oscillator
  input wire logic rc_clk,
  // cpu core and option bits
  input wire logic watchdog_refresh_instruction,
  input wire logic always_on_option,
  input wire logic timeout_reset_select_option,
  input wire logic debug_mode,
  input wire logic stop_mode,
  // register port
  input wire logic [wdt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wdt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [wdt_pkg::DATA_W-1:0] reg_rdata,
  // interrupt controller
  output logic irq,
  output logic [15:0] irq_vector,
  // reset and stop-mode recovery
  output logic reset_req,
  output logic stop_recovery
);
  import wdt_pkg::*;

  typedef struct packed {
    wdt_state_e state;
    logic [CNT_W-1:0] count;
    logic [7:0] reload_upper_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] reload_low_byte;
    logic [1:0] status;
    logic [1:0] mask;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic [15:0] vector;
    logic stop_recovery;
    logic reset_trig;
    logic rc_prev;
  } wdt_s;

  wdt_s st_reg;
  wdt_s st_next;

  logic rc_sync;
  logic reset_hold;
  logic rc_tick;
  logic [CNT_W-1:0] reload_value;
  logic refresh_ok;
  logic enable_req;
  logic timeout_evt;
  logic [1:0] status_set;
  logic [1:0] status_clr;
  logic [DATA_W-1:0] ctrl_view;

  // the rc clock is never used as a clock here: sampling it keeps one
  // domain, at the cost of edge jitter of one system cycle per tick
  wdt_sync2 u_rc_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(rc_clk),
    .sync_out(rc_sync)
  );

  // one decrement per rc period, so the period is reload / 10 ms
  assign rc_tick = rc_sync & ~st_reg.rc_prev;

  assign reload_value = {st_reg.reload_upper_byte,
                         st_reg.reload_high_byte,
                         st_reg.reload_low_byte};

  // no late refresh: a reload below three would hit this window at once
  assign refresh_ok = watchdog_refresh_instruction &&
    (st_reg.count > COUNT_NO_REFRESH);

  assign enable_req = watchdog_refresh_instruction ||
    always_on_option;

  assign timeout_evt = (st_reg.state == ST_RUN) && rc_tick &&
    !debug_mode && (st_reg.count == COUNT_ONE);

  always_comb begin
    ctrl_view = '0;
    ctrl_view[CTRL_TIMEOUT_BIT] = st_reg.status[CTRL_TIMEOUT_BIT];
    ctrl_view[CTRL_STOP_BIT] = st_reg.status[CTRL_STOP_BIT];
    ctrl_view[CTRL_RUN_BIT] = (st_reg.state != ST_OFF);
    ctrl_view[CTRL_RESMODE_BIT] = timeout_reset_select_option;
  end

  always_comb begin
    st_next = st_reg;
    st_next.rc_prev = rc_sync;
    st_next.stop_recovery = 1'b0;
    st_next.reset_trig = 1'b0;
    st_next.rdata = '0;
    st_next.vector = WDT_VECTOR;
    status_set = 2'b00;
    status_clr = 2'b00;

    // counter and mode state
    case (st_reg.state)
      ST_OFF: begin
        if (enable_req) begin
          st_next.count = reload_value;
          st_next.state = ST_RUN;
        end
      end
      ST_RUN: begin
        // no path back to off: only a reset stops it
        if (debug_mode) begin
          st_next.count = reload_value;
        end else if (refresh_ok) begin
          st_next.count = reload_value;
        end else if (rc_tick) begin
          if (st_reg.count == COUNT_ZERO) begin
            st_next.count = COUNT_MAX;
          end else begin
            st_next.count = st_reg.count - COUNT_ONE;
          end
        end
        if (timeout_evt) begin
          if (timeout_reset_select_option) begin
            st_next.reset_trig = 1'b1;
            st_next.state = ST_FIRED;
          end else begin
            status_set[CTRL_TIMEOUT_BIT] = 1'b1;
            if (stop_mode) begin
              status_set[CTRL_STOP_BIT] = 1'b1;
              st_next.stop_recovery = 1'b1;
            end
          end
        end
      end
      ST_FIRED: begin
        // parked at zero until the reset it requested arrives
        st_next.count = COUNT_ZERO;
      end
      default: begin
        st_next.state = ST_OFF;
        st_next.count = COUNT_RST;
      end
    endcase

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        OFF_RELOAD_UPPER: begin
          st_next.reload_upper_byte = reg_wdata;
        end
        OFF_RELOAD_HIGH: begin
          st_next.reload_high_byte = reg_wdata;
        end
        OFF_RELOAD_LOW: begin
          st_next.reload_low_byte = reg_wdata;
        end
        OFF_CTRL: begin
          status_clr[CTRL_TIMEOUT_BIT] = reg_wdata[CTRL_TIMEOUT_BIT];
          status_clr[CTRL_STOP_BIT] = reg_wdata[CTRL_STOP_BIT];
        end
        OFF_MASK: begin
          st_next.mask = reg_wdata[1:0];
        end
        default: begin
          st_next.mask = st_reg.mask;
        end
      endcase
    end

    // sticky status: a time-out in the clearing cycle survives
    st_next.status = (st_reg.status & ~status_clr) | status_set;

    // register reads, answered in the next cycle only
    if (reg_rd) begin
      case (reg_addr)
        OFF_RELOAD_UPPER: begin
          st_next.rdata = st_reg.reload_upper_byte;
        end
        OFF_RELOAD_HIGH: begin
          st_next.rdata = st_reg.reload_high_byte;
        end
        OFF_RELOAD_LOW: begin
          st_next.rdata = st_reg.reload_low_byte;
        end
        OFF_CTRL: begin
          st_next.rdata = ctrl_view;
        end
        OFF_MASK: begin
          st_next.rdata = {6'h00, st_reg.mask};
        end
        OFF_COUNT_UPPER: begin
          st_next.rdata = st_reg.count[23:16];
        end
        OFF_COUNT_HIGH: begin
          st_next.rdata = st_reg.count[15:8];
        end
        OFF_COUNT_LOW: begin
          st_next.rdata = st_reg.count[7:0];
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end

    // level interrupt from unmasked sticky bits
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.state <= ST_OFF;
      st_reg.count <= COUNT_RST;
      st_reg.reload_upper_byte <= RELOAD_BYTE_RST;
      st_reg.reload_high_byte <= RELOAD_BYTE_RST;
      st_reg.reload_low_byte <= RELOAD_BYTE_RST;
      st_reg.status <= 2'h0;
      st_reg.mask <= MASK_RST;
      st_reg.rdata <= 8'h00;
      st_reg.irq <= 1'b0;
      st_reg.vector <= WDT_VECTOR;
      st_reg.stop_recovery <= 1'b0;
      st_reg.reset_trig <= 1'b0;
      st_reg.rc_prev <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // short pulse widened so a slower reset controller still sees it
  wdt_reset_stretch u_reset_stretch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .trig(st_reg.reset_trig),
    .hold_out(reset_hold)
  );

  assign reg_rdata = st_reg.rdata;
  assign irq = st_reg.irq;
  assign irq_vector = st_reg.vector;
  assign stop_recovery = st_reg.stop_recovery;
  assign reset_req = reset_hold;
endmodule // watchdog_timer_24bit
`default_nettype wire

// file: design/wdt_pkg.sv
// shared constants and types for the 24-bit watchdog
`default_nettype none
package wdt_pkg;
  // register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W = 24;

  // register offsets
  localparam logic [2:0] OFF_RELOAD_UPPER = 3'h0;
  localparam logic [2:0] OFF_RELOAD_HIGH = 3'h1;
  localparam logic [2:0] OFF_RELOAD_LOW = 3'h2;
  localparam logic [2:0] OFF_CTRL = 3'h3;
  localparam logic [2:0] OFF_MASK = 3'h4;
  localparam logic [2:0] OFF_COUNT_UPPER = 3'h5;
  localparam logic [2:0] OFF_COUNT_HIGH = 3'h6;
  localparam logic [2:0] OFF_COUNT_LOW = 3'h7;

  // control register field positions
  localparam int CTRL_TIMEOUT_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_RESMODE_BIT = 3;

  // values after reset
  localparam logic [7:0] RELOAD_BYTE_RST = 8'hff;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [23:0] COUNT_RST = 24'h000000;

  // counter landmarks
  localparam logic [23:0] COUNT_MAX = 24'hffffff;
  localparam logic [23:0] COUNT_NO_REFRESH = 24'h000002;
  localparam logic [23:0] COUNT_ZERO = 24'h000000;
  localparam logic [23:0] COUNT_ONE = 24'h000001;

  // interrupt vector in program memory
  localparam logic [15:0] WDT_VECTOR = 16'h0004;

  // timing
  localparam int RC_FREQ_HZ = 10000;
  localparam int TIMEOUT_DIV = 10;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_HOLD_NS = 64;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 5;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_FIRED = 3'b100
  } wdt_state_e;
endpackage
`default_nettype wire

// file: design/wdt_reset_stretch.sv
// stretches a time-out pulse into a held reset request
`default_nettype none
module wdt_reset_stretch
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // trigger pulse and held request
  input wire logic trig,
  output logic hold_out
);
  typedef struct packed {
    logic [HOLD_W-1:0] cnt;
    logic hold;
  } stretch_s;

  stretch_s st_reg;
  stretch_s st_next;

  always_comb begin
    st_next = st_reg;
    if (trig) begin
      st_next.cnt = HOLD_W'(RESET_HOLD_CYCLES - 1);
      st_next.hold = 1'b1;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - HOLD_W'(1);
    end else begin
      st_next.hold = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hold_out = st_reg.hold;
endmodule // wdt_reset_stretch

// file: design/wdt_sync2.sv
// two flip-flop synchroniser for one level
`default_nettype none
module wdt_sync2 (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.meta = async_in;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stable;
endmodule // wdt_sync2

// file: tb/watchdog_monitor.sv
// assertion checker for the watchdog timer ports
`default_nettype none
module watchdog_monitor
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // inputs watched
  input wire logic timeout_reset_select_option,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic [wdt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  // outputs watched
  input wire logic [wdt_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic [15:0] irq_vector,
  input wire logic reset_req,
  input wire logic stop_recovery
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_vec; $rose(irq) |-> irq_vector == WDT_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  // irq and a control read both come from the same status flops; the read
  // shows the status of the strobe cycle, so compare with irq of that cycle
  property p_rd_irq;
    $past(reg_rd && reg_addr == OFF_CTRL && irq) |-> reg_rdata[1:0] != 2'h0;
  endproperty
  a_rd_irq: assert property (p_rd_irq) else $error("irq w/o status");
  property p_irq_mode; $rose(irq) |-> !timeout_reset_select_option; endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("irq in reset mode");
  property p_rst_mode; $rose(reset_req) |-> timeout_reset_select_option; endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("reset in irq mode");
  property p_rst_len;
    $rose(reset_req) |-> reset_req [*8] ##1 reset_req [*8] ##1 !reset_req;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset length");
  property p_rst_once; $fell(reset_req) |-> !reset_req [*8]; endproperty
  a_rst_once: assert property (p_rst_once) else $error("second reset");
  property p_dbg;
    debug_mode [*6] |-> !$rose(irq) && !$rose(reset_req) && !stop_recovery;
  endproperty
  a_dbg: assert property (p_dbg) else $error("timeout in debug");
  property p_sr;
    stop_recovery |-> ($past(stop_mode) && !timeout_reset_select_option)
      ##1 !stop_recovery;
  endproperty
  a_sr: assert property (p_sr) else $error("bad stop recovery");
  // read data stand only in the cycle after a read strobe
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
  c_irq: cover property ($rose(irq));
  c_rst: cover property ($rose(reset_req));
  c_sr: cover property (stop_recovery);
endmodule // watchdog_monitor
bind watchdog_timer_24bit watchdog_monitor mon (.sys_clk, .rst_n,
  .timeout_reset_select_option, .debug_mode, .stop_mode, .reg_addr,
  .reg_rd, .reg_rdata, .irq, .irq_vector, .reset_req, .stop_recovery);
`default_nettype wire

// file: tb/watchdog_timer_24bit_test.sv
// self-checking bench for the watchdog timer
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %0t: got %h want %h", $time, g, e); end end
module watchdog_timer_24bit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;
  logic sys_clk = 1'h0, rst_n = 1'h0, rc_run = 1'h0, rc_clk;
  logic refresh = 1'h0, aon = 1'h0, res_sel = 1'h0, dbg = 1'h0, stop = 1'h0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, rst_len, sr_cnt;
  logic wr = 1'h0, rd = 1'h0, irq, rreq, srec;
  logic [15:0] vec, vec_seen;
  int fails = 0, checks = 0, cyc = 0;
  watchdog_timer_24bit dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .rc_clk(rc_clk), .watchdog_refresh_instruction(refresh),
    .always_on_option(aon), .timeout_reset_select_option(res_sel),
    .debug_mode(dbg), .stop_mode(stop), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq(irq),
    .irq_vector(vec), .reset_req(rreq), .stop_recovery(srec));
  wdt_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .rc_run(rc_run),
    .rc_clk(rc_clk), .irq(irq), .irq_vector(vec), .reset_req(rreq),
    .stop_recovery(srec), .vec_seen(vec_seen), .rst_len(rst_len),
    .sr_cnt(sr_cnt));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic close_out;
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge sys_clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e,
                        input logic [7:0] m = 8'hff);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge sys_clk);
    rd <= 1'h0;
    @(negedge sys_clk);
    `CHK(rdata & m, e)
  endtask
  // n rc rising edges, then settle so the last tick has landed
  task automatic tick(input int n);
    @(posedge sys_clk);
    rc_run <= 1'h1;
    repeat (8 * n) @(posedge sys_clk);
    rc_run <= 1'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic kick;
    @(posedge sys_clk);
    refresh <= 1'h1;
    @(posedge sys_clk);
    refresh <= 1'h0;
  endtask
  // reload never below four, as software must keep it
  task automatic load(input logic [7:0] lo);
    wr_reg(OFF_RELOAD_UPPER, 8'h00);
    wr_reg(OFF_RELOAD_HIGH, 8'h00);
    wr_reg(OFF_RELOAD_LOW, lo);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(3'(i), i < 3 ? 8'hff : 8'h00);
    end
    wr_reg(OFF_COUNT_LOW, 8'h55);
    load(8'h40);
    tick(2);
    rd_reg(OFF_COUNT_LOW, 8'h00);
    kick();
    rd_reg(OFF_COUNT_LOW, 8'h40);
    rd_reg(OFF_CTRL, 8'h04);
    tick(3);
    rd_reg(OFF_COUNT_LOW, 8'h3d);
    kick();
    rd_reg(OFF_COUNT_LOW, 8'h40);
    load(8'h04);
    wr_reg(OFF_MASK, 8'h01);
    kick();
    tick(2);
    kick();
    rd_reg(OFF_COUNT_LOW, 8'h02);
    tick(2);
    `CHK(irq, 1'h1)
    `CHK(vec_seen, WDT_VECTOR)
    rd_reg(OFF_CTRL, 8'h05);
    tick(1);
    rd_reg(OFF_COUNT_UPPER, 8'hff);
    rd_reg(OFF_COUNT_LOW, 8'hff);
    wr_reg(OFF_CTRL, 8'h01);
    rd_reg(OFF_CTRL, 8'h04);
    `CHK(irq, 1'h0)
    @(posedge sys_clk);
    stop <= 1'h1;
    wr_reg(OFF_MASK, 8'h02);
    kick();
    tick(4);
    `CHK(sr_cnt, 8'h01)
    `CHK(irq, 1'h1)
    rd_reg(OFF_CTRL, 8'h07);
    wr_reg(OFF_MASK, 8'h00);
    rd_reg(OFF_MASK, 8'h00);
    `CHK(irq, 1'h0)
    wr_reg(OFF_CTRL, 8'h03);
    stop <= 1'h0;
    kick();
    dbg <= 1'h1;
    tick(6);
    rd_reg(OFF_COUNT_LOW, 8'h04);
    rd_reg(OFF_CTRL, 8'h04);
    @(posedge sys_clk);
    dbg <= 1'h0;
    res_sel <= 1'h1;
    wr_reg(OFF_MASK, 8'h03);
    kick();
    tick(4);
    repeat (24) @(posedge sys_clk);
    `CHK(rst_len, 8'h10)
    `CHK(irq, 1'h0)
    rd_reg(OFF_CTRL, 8'h08, 8'h0b);
    @(posedge sys_clk);
    rst_n <= 1'h0;
    aon <= 1'h1;
    res_sel <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    tick(1);
    rd_reg(OFF_COUNT_UPPER, 8'hff);
    rd_reg(OFF_COUNT_LOW, 8'hfe);
    close_out();
  end
endmodule // watchdog_timer_24bit_test
`default_nettype wire

// file: tb/wdt_cpu_model.sv
// far-side model: rc oscillator plus capture of watchdog events
`default_nettype none
module wdt_cpu_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // oscillator gate and output
  input wire logic rc_run,
  output logic rc_clk,
  // watchdog events
  input wire logic irq,
  input wire logic [15:0] irq_vector,
  input wire logic reset_req,
  input wire logic stop_recovery,
  output logic [15:0] vec_seen,
  output logic [7:0] rst_len,
  output logic [7:0] sr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  logic irq_d;
  // period cut to 8 system cycles to keep runs short; held low when gated
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 3'h0;
      rc_clk <= 1'h0;
      irq_d <= 1'h0;
      vec_seen <= 16'h0000;
      rst_len <= 8'h00;
      sr_cnt <= 8'h00;
    end else begin
      ph <= rc_run ? ph + 3'h1 : 3'h0;
      rc_clk <= rc_run & ~ph[2];
      irq_d <= irq;
      if (irq & ~irq_d) vec_seen <= irq_vector;
      if (reset_req) rst_len <= rst_len + 8'h01;
      if (stop_recovery) sr_cnt <= sr_cnt + 8'h01;
    end
  end
endmodule // wdt_cpu_model
`default_nettype wire
